// ==== shared/aspi_regs.vh ====
`ifndef ASPI_REGS_VH
`define ASPI_REGS_VH
// Interface mode field
`define ASPI_MODE_W 2
`define ASPI_MODE_SERIAL 2'h3
// Result word layout and the shared bits carried by this block
`define ASPI_RESULT_W 18
`define ASPI_RESULT_MSB 17
`define ASPI_BIT_SYNC 12
`define ASPI_BIT_ERR 13
`define ASPI_BIT_P14 14
`define ASPI_BIT_P15 15
`define ASPI_BIT_P16 16
// Bit counter width and its load value (result width minus one)
`define ASPI_CNT_W 5
`define ASPI_CNT_LAST 5'h11
`define ASPI_CNT_ZERO 5'h00
// Master serial clock: half-period count reload value (half period is this plus one system cycle)
`define ASPI_HALF_W 4
`define ASPI_HALF_CYC 4'h4
`define ASPI_HALF_ZERO 4'h0
// Result buffer
`define ASPI_FIFO_DEPTH 16
`define ASPI_FIFO_AW 4
// Serial configuration register width
`define ASPI_CFG_W 16
// Synchronised pin vector: positions
`define ASPI_SY_W 10
`define ASPI_SY_MODE_LO 0
`define ASPI_SY_MODE_HI 1
`define ASPI_SY_CSRC 2
`define ASPI_SY_SPOL 3
`define ASPI_SY_INV 4
`define ASPI_SY_CFGSRC 5
`define ASPI_SY_CFGDAT 6
`define ASPI_SY_CFGCLK 7
`define ASPI_SY_SERIAL_DATA_CLOCK 8
`define ASPI_SY_SPARE 9
`endif

// ==== logic/aspi_top.v ====
`include "aspi_regs.vh"

// Result buffer: valid/ready on both sides, honest full and empty
module aspi_fifo #(
  parameter WIDTH = `ASPI_RESULT_W,
  parameter DEPTH = `ASPI_FIFO_DEPTH,
  parameter AW = `ASPI_FIFO_AW
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q, rd_q;
  reg ready_q;
  wire push, pop;
  wire [AW:0] wr_d, rd_d;

  // Ready leaves a flop, worked out from the next pointers so it never lags
  assign in_ready = ready_q;
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign wr_d = push ? wr_q + 1'b1 : wr_q;
  assign rd_d = pop ? rd_q + 1'b1 : rd_q;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
      ready_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      // Extra pointer bit tells full from empty
      ready_q <= (wr_d[AW] == rd_d[AW]) || (wr_d[AW-1:0] != rd_d[AW-1:0]);
    end
  end
endmodule

module aspi_top #(
  parameter CFG_W = `ASPI_CFG_W,
  parameter FIFO_DEPTH = `ASPI_FIFO_DEPTH
) (
  input wire CLK_SYS,
  input wire RESETN,
  input wire [`ASPI_MODE_W-1:0] MODE,
  input wire CLOCK_SOURCE_SELECT,
  input wire FRAME_SYNC_POLARITY_SELECT,
  input wire CLOCK_EDGE_INVERT,
  input wire [CFG_W-1:0] HW_CONFIG,
  input wire RESULT_VALID,
  output wire RESULT_READY,
  input wire [`ASPI_RESULT_W-1:0] RESULT_DATA,
  input wire CONV_START,
  output reg PIN_D12_O,
  output reg PIN_D13_O,
  input wire PIN_D14_I,
  output reg PIN_D14_O,
  output reg PIN_D14_OE,
  input wire PIN_D15_I,
  output reg PIN_D15_O,
  output reg PIN_D15_OE,
  input wire PIN_D16_I,
  output reg PIN_D16_O,
  output reg PIN_D16_OE,
  input wire SERIAL_DATA_CLOCK_I,
  output reg SERIAL_DATA_CLOCK_O,
  output reg SERIAL_DATA_CLOCK_OE,
  output reg SERIAL_RESULT_OUTPUT_O,
  output reg [CFG_W-1:0] CONFIG_ACTIVE
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LOADED = 3'b010;
  localparam ST_SHIFT = 3'b100;

  // Active edge of a sampled clock, chosen by the invert select
  function edge_hit;
    input cur;
    input prev;
    input inv;
    begin
      edge_hit = inv ? (prev && !cur) : (!prev && cur);
    end
  endfunction

  reg [`ASPI_SY_W-1:0] sy1_q, sy2_q;
  reg [CFG_W-1:0] hw1_q, hw2_q, cfg_shift_q;
  reg cfgclk_prev_q, serial_data_clock_prev_q, mclk_q, err_q, err_d, pop;
  reg [2:0] state_q, state_d;
  reg [`ASPI_RESULT_W-1:0] word_q, par_q;
  reg [`ASPI_CNT_W-1:0] cnt_q;
  reg [`ASPI_HALF_W-1:0] half_q;
  wire [`ASPI_SY_W-1:0] sy_in;
  wire [`ASPI_RESULT_W-1:0] fifo_data;
  wire fifo_valid, serial, master, slave, inv, cfg_edge, sd_edge, half_done, m_edge, s_adv;

  assign sy_in = {1'b0, SERIAL_DATA_CLOCK_I, PIN_D16_I, PIN_D15_I, PIN_D14_I, CLOCK_EDGE_INVERT,
                  FRAME_SYNC_POLARITY_SELECT, CLOCK_SOURCE_SELECT, MODE};

  // Two flops on every pin input except CONV_START before any logic looks at it
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sy1_q <= {`ASPI_SY_W{1'b0}};
      sy2_q <= {`ASPI_SY_W{1'b0}};
      hw1_q <= {CFG_W{1'b0}};
      hw2_q <= {CFG_W{1'b0}};
    end else begin
      sy1_q <= sy_in;
      sy2_q <= sy1_q;
      hw1_q <= HW_CONFIG;
      hw2_q <= hw1_q;
    end
  end

  assign serial = (sy2_q[`ASPI_SY_MODE_HI:`ASPI_SY_MODE_LO] == `ASPI_MODE_SERIAL);
  assign master = serial && !sy2_q[`ASPI_SY_CSRC];
  assign slave = serial && sy2_q[`ASPI_SY_CSRC];
  assign inv = sy2_q[`ASPI_SY_INV];
  assign cfg_edge = edge_hit(sy2_q[`ASPI_SY_CFGCLK], cfgclk_prev_q, inv);
  assign sd_edge = edge_hit(sy2_q[`ASPI_SY_SERIAL_DATA_CLOCK], serial_data_clock_prev_q, inv);

  aspi_fifo #(
    .WIDTH(`ASPI_RESULT_W),
    .DEPTH(FIFO_DEPTH),
    .AW(`ASPI_FIFO_AW)
  ) u_fifo (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .in_valid(RESULT_VALID),
    .in_ready(RESULT_READY),
    .in_data(RESULT_DATA),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // Serial configuration capture, MSB first into the low end
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cfgclk_prev_q <= 1'b0;
      serial_data_clock_prev_q <= 1'b0;
      cfg_shift_q <= {CFG_W{1'b0}};
      CONFIG_ACTIVE <= {CFG_W{1'b0}};
    end else begin
      cfgclk_prev_q <= sy2_q[`ASPI_SY_CFGCLK];
      serial_data_clock_prev_q <= sy2_q[`ASPI_SY_SERIAL_DATA_CLOCK];
      // Hardware select freezes the serial path so stray clocks do nothing
      if (serial && !sy2_q[`ASPI_SY_CFGSRC] && cfg_edge) begin
        cfg_shift_q <= {cfg_shift_q[CFG_W-2:0], sy2_q[`ASPI_SY_CFGDAT]};
      end
      if (serial && !sy2_q[`ASPI_SY_CFGSRC]) begin
        CONFIG_ACTIVE <= cfg_shift_q;
      end else begin
        CONFIG_ACTIVE <= hw2_q;
      end
    end
  end

  // Master clock divider: data moves on the idle-going edge, stable at the active one
  assign half_done = (half_q == `ASPI_HALF_ZERO);
  assign m_edge = master && (state_q == ST_SHIFT) && half_done && (mclk_q != inv);
  assign s_adv = slave && (state_q != ST_IDLE) && sd_edge;

  // Transfer sequencer
  always @* begin
    state_d = state_q;
    err_d = 1'b0;
    pop = 1'b0;
    case (state_q)
      ST_IDLE: begin
        pop = !serial || fifo_valid;
        if (serial && fifo_valid) begin
          state_d = master ? ST_SHIFT : ST_LOADED;
        end
      end
      ST_LOADED: begin
        if (!slave) begin
          state_d = ST_IDLE;
        end else if (CONV_START) begin
          state_d = ST_IDLE; // Unread word replaced by newer result
        end else if (sd_edge) begin
          state_d = (cnt_q == `ASPI_CNT_ZERO) ? ST_IDLE : ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!serial) begin
          state_d = ST_IDLE;
        end else if (slave && CONV_START) begin
          state_d = ST_IDLE;
          err_d = 1'b1;
        end else if ((m_edge || s_adv) && cnt_q == `ASPI_CNT_ZERO) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
      word_q <= {`ASPI_RESULT_W{1'b0}};
      par_q <= {`ASPI_RESULT_W{1'b0}};
      cnt_q <= `ASPI_CNT_ZERO;
      half_q <= `ASPI_HALF_CYC;
      mclk_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      err_q <= err_d;
      if (pop && fifo_valid) begin
        word_q <= fifo_data;
        cnt_q <= `ASPI_CNT_LAST;
        if (!serial) begin
          par_q <= fifo_data;
        end
      end else if (m_edge || s_adv) begin
        word_q <= {word_q[`ASPI_RESULT_MSB-1:0], 1'b0};
        cnt_q <= cnt_q - 1'b1;
      end
      // Master clock runs only during a frame and rests at its idle level
      if (master && state_q == ST_SHIFT) begin
        half_q <= half_done ? `ASPI_HALF_CYC : half_q - 1'b1;
        if (half_done) begin
          mclk_q <= !mclk_q;
        end
      end else begin
        half_q <= `ASPI_HALF_CYC;
        mclk_q <= inv;
      end
    end
  end

  // Shared pin drivers, all registered
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PIN_D12_O <= 1'b0;
      PIN_D13_O <= 1'b0;
      PIN_D14_O <= 1'b0;
      PIN_D15_O <= 1'b0;
      PIN_D16_O <= 1'b0;
      PIN_D14_OE <= 1'b0;
      PIN_D15_OE <= 1'b0;
      PIN_D16_OE <= 1'b0;
      SERIAL_DATA_CLOCK_O <= 1'b0;
      SERIAL_DATA_CLOCK_OE <= 1'b0;
      SERIAL_RESULT_OUTPUT_O <= 1'b0;
    end else begin
      if (!serial) begin
        PIN_D12_O <= par_q[`ASPI_BIT_SYNC];
        PIN_D13_O <= par_q[`ASPI_BIT_ERR];
      end else if (master) begin
        // Polarity xor frame-active gives high or low sync during data
        PIN_D12_O <= (state_q == ST_SHIFT) ^ sy2_q[`ASPI_SY_SPOL];
        PIN_D13_O <= 1'b0;
      end else begin
        PIN_D12_O <= 1'b0;
        PIN_D13_O <= err_q;
      end
      PIN_D14_O <= par_q[`ASPI_BIT_P14];
      PIN_D15_O <= par_q[`ASPI_BIT_P15];
      PIN_D16_O <= par_q[`ASPI_BIT_P16];
      PIN_D14_OE <= !serial;
      PIN_D15_OE <= !serial;
      PIN_D16_OE <= !serial;
      SERIAL_DATA_CLOCK_O <= master ? mclk_q : 1'b0;
      SERIAL_DATA_CLOCK_OE <= master;
      SERIAL_RESULT_OUTPUT_O <= serial && (state_q != ST_IDLE) && word_q[`ASPI_RESULT_MSB];
    end
  end
endmodule

// ==== dv/aspi_top_sva.sv ====
module aspi_top_sva #(
  parameter CFG_W = 16
) (
  input wire CLK_SYS,
  input wire RESETN,
  input wire [1:0] MODE,
  input wire CLOCK_SOURCE_SELECT,
  input wire FRAME_SYNC_POLARITY_SELECT,
  input wire CLOCK_EDGE_INVERT,
  input wire [CFG_W-1:0] HW_CONFIG,
  input wire CONV_START,
  input wire PIN_D12_O,
  input wire PIN_D13_O,
  input wire PIN_D14_I,
  input wire PIN_D14_OE,
  input wire PIN_D16_I,
  input wire SERIAL_DATA_CLOCK_OE,
  input wire [CFG_W-1:0] CONFIG_ACTIVE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // Mode decode at the pins; runs of 5 or more cycles cover the synchroniser lag
  wire mst = MODE == 2'h3 && !CLOCK_SOURCE_SELECT;
  wire slv = MODE == 2'h3 && CLOCK_SOURCE_SELECT;
  wire sfg = MODE == 2'h3 && !PIN_D14_I && !CLOCK_EDGE_INVERT;
  par_drive_a: assert property ((MODE != 2'h3)[*5] |-> PIN_D14_OE)
    else $error("parallel pin not driven");
  mst_clock_a: assert property (mst[*5] |-> SERIAL_DATA_CLOCK_OE && !PIN_D14_OE)
    else $error("master clock not driven");
  sync_high_a: assert property ((mst && !FRAME_SYNC_POLARITY_SELECT)[*6] ##0 $rose(PIN_D12_O) |=> PIN_D12_O[*8])
    else $error("high sync cut short");
  sync_low_a: assert property ((mst && FRAME_SYNC_POLARITY_SELECT)[*6] ##0 $fell(PIN_D12_O) |=> !PIN_D12_O[*8])
    else $error("low sync cut short");
  err_pulse_a: assert property (slv[*5] ##0 $rose(PIN_D13_O) |=> !PIN_D13_O)
    else $error("error flag longer than one cycle");
  err_cause_a: assert property (slv[*5] ##0 $rose(PIN_D13_O) |-> $past(CONV_START, 2))
    else $error("error flag without conversion start");
  hw_config_a: assert property ((PIN_D14_I && $stable(HW_CONFIG))[*6] |-> CONFIG_ACTIVE == HW_CONFIG)
    else $error("hardware config not selected");
  cfg_edge_a: assert property (sfg[*6] ##0 $fell(PIN_D16_I) |-> $stable(CONFIG_ACTIVE)[*5])
    else $error("config shifted on wrong edge");
endmodule

bind aspi_top aspi_top_sva #(.CFG_W(CFG_W)) u_sva (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .MODE(MODE),
  .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT), .FRAME_SYNC_POLARITY_SELECT(FRAME_SYNC_POLARITY_SELECT),
  .CLOCK_EDGE_INVERT(CLOCK_EDGE_INVERT), .HW_CONFIG(HW_CONFIG), .CONV_START(CONV_START), .PIN_D12_O(PIN_D12_O),
  .PIN_D13_O(PIN_D13_O), .PIN_D14_I(PIN_D14_I), .PIN_D14_OE(PIN_D14_OE), .PIN_D16_I(PIN_D16_I),
  .SERIAL_DATA_CLOCK_OE(SERIAL_DATA_CLOCK_OE), .CONFIG_ACTIVE(CONFIG_ACTIVE));

// ==== dv/aspi_host.sv ====
module aspi_host;
  timeunit 1ns;
  timeprecision 100ps;
  reg serial_data_clock = 1'b0;
  reg cdat = 1'b0;
  reg cclk = 1'b0;
  // Config word MSB first; data moves while the clock rests
  task cfg(input [15:0] w, input inv);
    integer i;
    cclk <= inv;
    for (i = 15; i >= 0; i--) begin
      cdat <= w[i];
      #62.5 cclk <= !inv;
      #62.5 cclk <= inv;
    end
    #62.5 cdat <= !cdat; // Released line must not keep the last bit
  endtask
  // Slave read clock; stands still at the rest level between calls
  task sclk(input integer n, input inv);
    serial_data_clock <= inv;
    repeat (n) begin
      #62.5 serial_data_clock <= !inv;
      #62.5 serial_data_clock <= inv;
    end
  endtask
endmodule

// ==== dv/aspi_top_tb.sv ====
module aspi_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [1:0] mode = 2'h0;
  reg css = 1'b0;
  reg pol = 1'b0;
  reg inv = 1'b0;
  reg src = 1'b1;
  reg [15:0] hw = 16'h9D17;
  reg rv = 1'b0;
  reg [17:0] rd = 18'h00000;
  reg cs = 1'b0;
  wire rdy, d12, d13, d14, d15, d16, o14, o15, o16, sck, sckoe, sdo;
  wire [15:0] cfgq;
  integer fail_count = 0;
  integer n_compared = 0;
  aspi_host HOST ();
  // Shared wires resolve from whichever side enables its driver
  aspi_top DUT (.CLK_SYS(clk), .RESETN(rstn), .MODE(mode), .CLOCK_SOURCE_SELECT(css),
    .FRAME_SYNC_POLARITY_SELECT(pol), .CLOCK_EDGE_INVERT(inv), .HW_CONFIG(hw), .RESULT_VALID(rv),
    .RESULT_READY(rdy), .RESULT_DATA(rd), .CONV_START(cs), .PIN_D12_O(d12), .PIN_D13_O(d13),
    .PIN_D14_I(o14 ? d14 : src), .PIN_D14_O(d14), .PIN_D14_OE(o14), .PIN_D15_I(o15 ? d15 : HOST.cdat),
    .PIN_D15_O(d15), .PIN_D15_OE(o15), .PIN_D16_I(o16 ? d16 : HOST.cclk), .PIN_D16_O(d16), .PIN_D16_OE(o16),
    .SERIAL_DATA_CLOCK_I(sckoe ? sck : HOST.serial_data_clock), .SERIAL_DATA_CLOCK_O(sck), .SERIAL_DATA_CLOCK_OE(sckoe), .SERIAL_RESULT_OUTPUT_O(sdo), .CONFIG_ACTIVE(cfgq));
  always #4 clk = ~clk;
  task chk(input string nm, input [17:0] e, input [17:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Valid and data held until the edge that sees ready
  task push(input [17:0] w);
    integer t;
    rv <= 1'b1;
    rd <= w;
    t = 0;
    cyc(1);
    while (rdy !== 1'b1 && t < 500) begin
      t++;
      cyc(1);
    end
    rv <= 1'b0;
  endtask
  task t_par;
    integer m;
    reg [17:0] w;
    for (m = 0; m < 3; m++) begin
      w = {1'b0, 5'h15 ^ m[4:0], 12'h3C6};
      mode <= m[1:0];
      cyc(5);
      push(w);
      cyc(4);
      chk("parallel bits", w[16:12], {d16, d15, d14, d13, d12});
      chk("parallel enables", 3'h7, {o16, o15, o14});
    end
  endtask
  // Rebuild the frame from the data line at each active clock edge
  task t_mst(input p, input i);
    integer t;
    integer n;
    reg [17:0] sh;
    reg last;
    mode <= 2'h3;
    css <= 1'b0;
    pol <= p;
    inv <= i;
    cyc(8);
    push(18'h2C3A1);
    t = 0;
    while (d12 !== !p && t < 50) begin
      t++;
      cyc(1);
    end
    chk("msb at sync", 1'b1, sdo);
    n = 0;
    sh = 18'h00000;
    last = sck;
    while (d12 === !p && t < 400) begin
      t++;
      cyc(1);
      if (sck !== last && sck === !i) begin
        sh = {sh[16:0], sdo};
        n++;
      end
      last = sck;
    end
    chk("frame under sync", 18'h2C3A1, sh);
    chk("edges under sync", 18'h12, n[17:0]);
    chk("sync idle", p, d12);
  endtask
  task t_slv;
    integer k;
    reg [17:0] sh;
    mode <= 2'h3;
    css <= 1'b1;
    inv <= 1'b0;
    cyc(8);
    k = 0;
    rv <= 1'b1;
    rd <= {1'b1, 5'h00, 12'h5A3};
    repeat (24) begin
      cyc(1);
      if (rdy === 1'b1) begin
        k++;
        rd <= {1'b1, k[4:0], 12'h5A3};
      end
    end
    rv <= 1'b0;
    chk("words taken", 18'h11, k[17:0]);
    chk("refused when full", 1'b0, rdy);
    sh = 18'h00000;
    repeat (18) begin
      sh = {sh[16:0], sdo};
      HOST.sclk(1, 1'b0);
    end
    chk("slave word", {1'b1, 5'h00, 12'h5A3}, sh);
    HOST.sclk(3, 1'b0);
    cyc(1);
    cs <= 1'b1;
    cyc(1);
    cs <= 1'b0;
    k = 0;
    repeat (8) begin
      cyc(1);
      if (d13 === 1'b1) k++;
    end
    chk("error pulse cycles", 18'h1, k[17:0]);
    // Next word read on falling edges, then a start before any read begins
    inv <= 1'b1;
    cyc(4);
    sh = 18'h00000;
    repeat (18) begin
      sh = {sh[16:0], sdo};
      HOST.sclk(1, 1'b1);
    end
    chk("slave word falling", {1'b1, 5'h02, 12'h5A3}, sh);
    cyc(1);
    cs <= 1'b1;
    cyc(1);
    cs <= 1'b0;
    k = 0;
    repeat (8) begin
      cyc(1);
      if (d13 === 1'b1) k++;
    end
    chk("no error before read", 18'h0, k[17:0]);
    mode <= 2'h0;
    cyc(40);
    chk("drained last word", 5'h10, {d16, d15, d14, d13, d12});
    chk("ready after drain", 1'b1, rdy);
  endtask
  task t_cfg;
    mode <= 2'h3;
    css <= 1'b0;
    inv <= 1'b0;
    src <= 1'b0;
    cyc(8);
    HOST.cfg(16'hB3C5, 1'b0);
    cyc(6);
    chk("serial config rise", 16'hB3C5, cfgq);
    inv <= 1'b1;
    cyc(8);
    HOST.cfg(16'h4E21, 1'b1);
    cyc(6);
    chk("serial config fall", 16'h4E21, cfgq);
    src <= 1'b1;
    HOST.cfg(16'h1111, 1'b1);
    cyc(6);
    chk("hardware config", 16'h9D17, cfgq);
    src <= 1'b0;
    cyc(8);
    chk("serial path ignored", 16'h4E21, cfgq);
  endtask
  // Main sequence after four cycles of reset
  initial begin
    cyc(4);
    rstn <= 1'b1;
    cyc(2);
    t_par;
    t_mst(1'b0, 1'b0);
    t_mst(1'b1, 1'b1);
    t_slv;
    t_cfg;
    results;
  end
  // Watchdog: well beyond the sixteen or so microseconds the tests need
  initial begin
    #200000;
    fail_count++;
    results;
  end
endmodule
